// *** rtl/lvtf_defs.vh ***
// Constants for the load value telemetry framer
`ifndef LVTF_DEFS_VH
`define LVTF_DEFS_VH
`define LVTF_CLK_HZ          200000000
`define LVTF_CYC_PER_MS      200000
`define LVTF_CAN_IVL_MIN_MS  16'd50
`define LVTF_CAN_IVL_MAX_MS  16'd5000
`define LVTF_SER_IVL_MIN_S   8'd1
`define LVTF_SER_IVL_MAX_S   8'd240
`define LVTF_STX             8'h02
`define LVTF_LEN             8'h16
`define LVTF_ETX             8'h03
`define LVTF_CR              8'h0d
`define LVTF_LF              8'h0a
`define LVTF_SP              8'h20
`define LVTF_COLON           8'h3a
`define LVTF_CAN_DLC         4'h8
`define LVTF_DEF_BAUD_DIV    16'd10417
`define LVTF_MODE_OFF        2'h0
`define LVTF_MODE_MEAS       2'h1
`define LVTF_MODE_LSR        2'h2
`define LVTF_MODE_DISP       2'h3
`define LVTF_RST_CAN_IVL     16'd500
`define LVTF_RST_CAN_ID      11'h210
`define LVTF_RST_DISP_DIG    2'd1
`define LVTF_MS_PER_S        18'd1000
`define LVTF_LSR_LAST        6'd19
`define LVTF_TXT_LAST        6'd61
`endif

// *** rtl/lvtf_framer.v ***
// Load value telemetry framer: CAN value frames and serial byte telegrams
`default_nettype none
`include "lvtf_defs.vh"

// How it works
// (R1) CAN frames repeat every 50..5000 ms
// (R2) Two 8-byte frames: base id, base+1
// (R3) ASCII line, eight labelled values, CR LF
// (R4) ASCII values carry decimals and unit
// (R5) Load frame: STX, LEN, floats, checksum, ETX
// (R6) Floats ordered a first, a second, b...
// (R7) Checksum is ones complement of floats
// (R8) Display feed: 4/5/6 digits, one value; CFG_DISP_SEL is unused here, digits are formatter bytes from index 0
// (R9) Serial interval 1 to 240 seconds
// (R10) Single-signal select forces adjustment mode
// (R11) Dual-signal select forces adjustment mode
// (R12) Whole full-scales; sum is 100% reference
// (R13) Analog scale from chosen full-scale
// (R14) Analog outputs follow logic units one/two
// (R15) Settings applied only on confirm
// (R16) Empty passwords plus master clears password
// (R17) Floats 32-bit, byte order a parameter
// (R18) Serial framing configurable, default 19200 8N1; not done here, bytes leave as SER_DATA words on a valid/ready handshake
module lvtf_framer #(
   parameter BIG_ENDIAN = 1,
   parameter CYC_PER_MS = `LVTF_CYC_PER_MS   // Shorter only to fit periods into a test run
) (
   input  wire        CLK,
   input  wire        RESET_N,
   input  wire        CFG_OK,
   input  wire        CFG_CAN_ON,
   input  wire [15:0] CFG_CAN_IVL_MS,
   input  wire [10:0] CFG_CAN_BASE_ID,
   input  wire [1:0]  CFG_SER_MODE,
   input  wire [7:0]  CFG_SER_IVL_S,
   input  wire [1:0]  CFG_DISP_DIGITS,
   input  wire [1:0]  CFG_DISP_SEL,
   input  wire        CFG_SINGLE_SIG,
   input  wire [15:0] CFG_FS_A,
   input  wire [15:0] CFG_FS_B,
   input  wire [15:0] CFG_FS_SUM,
   input  wire [2:0]  CFG_ANALOG_OUTPUT_ONE_SEL,
   input  wire [2:0]  CFG_ANALOG_OUTPUT_TWO_SEL,
   input  wire        CFG_PW_EMPTY,
   input  wire        CFG_MASTER_OK,
   input  wire [31:0] VAL_1A,
   input  wire [31:0] VAL_1B,
   input  wire [31:0] VAL_2A,
   input  wire [31:0] VAL_2B,
   input  wire [31:0] LKZ_A_FIRST,
   input  wire [31:0] LKZ_A_SECOND,
   input  wire [31:0] LKZ_B_FIRST,
   input  wire [31:0] LKZ_B_SECOND,
   input  wire [7:0]  ASCII_CHAR,
   output reg  [5:0]  ASCII_IDX,
   output reg         CAN_VALID,
   input  wire        CAN_READY,
   output reg  [10:0] CAN_ID,
   output reg  [3:0]  CAN_DLC,
   output reg  [63:0] CAN_DATA,
   output reg         SER_VALID,
   input  wire        SER_READY,
   output reg  [7:0]  SER_DATA,
   output reg         ADJUST_MODE,
   output reg         PW_CLEAR,
   output reg  [15:0] ANALOG_OUTPUT_ONE_FS,
   output reg  [15:0] ANALOG_OUTPUT_TWO_FS
);

   // ****************************************
   // Reset and confirmed settings
   // ****************************************
   reg        rst_s1;
   reg        rst_n;
   reg        can_on;
   reg [15:0] can_ivl;
   reg [10:0] base_id;
   reg [1:0]  ser_mode;
   reg [7:0]  ser_ivl;
   reg        single_sig;
   reg [1:0]  disp_dig;
   reg        ok_d;
   wire       ok_rise = CFG_OK & ~ok_d;

   // Synchronised release of the asynchronous reset
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // Settings latch on confirm; intervals clamped to their legal span
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ok_d        <= 1'b0;
         can_on      <= 1'b0;
         can_ivl     <= `LVTF_RST_CAN_IVL;
         base_id     <= `LVTF_RST_CAN_ID;
         disp_dig    <= `LVTF_RST_DISP_DIG;
         ser_mode    <= `LVTF_MODE_OFF;
         ser_ivl     <= 8'd1;
         single_sig  <= 1'b0;
         ADJUST_MODE <= 1'b0;
         PW_CLEAR    <= 1'b0;
         ANALOG_OUTPUT_ONE_FS    <= 16'h0000;
         ANALOG_OUTPUT_TWO_FS    <= 16'h0000;
      end else begin
         ok_d     <= CFG_OK;
         PW_CLEAR <= 1'b0;
         if (ok_rise) begin                                          // (R15)
            can_on   <= CFG_CAN_ON;
            base_id  <= CFG_CAN_BASE_ID;
            ser_mode <= CFG_SER_MODE;
            disp_dig <= CFG_DISP_DIGITS;
            if (CFG_CAN_IVL_MS < `LVTF_CAN_IVL_MIN_MS)
               can_ivl <= `LVTF_CAN_IVL_MIN_MS;                     // (R1)
            else if (CFG_CAN_IVL_MS > `LVTF_CAN_IVL_MAX_MS)
               can_ivl <= `LVTF_CAN_IVL_MAX_MS;
            else
               can_ivl <= CFG_CAN_IVL_MS;
            if (CFG_SER_IVL_S < `LVTF_SER_IVL_MIN_S)
               ser_ivl <= `LVTF_SER_IVL_MIN_S;                      // (R9)
            else if (CFG_SER_IVL_S > `LVTF_SER_IVL_MAX_S)
               ser_ivl <= `LVTF_SER_IVL_MAX_S;
            else
               ser_ivl <= CFG_SER_IVL_S;
            single_sig <= CFG_SINGLE_SIG;
            if (CFG_SINGLE_SIG != single_sig)
               ADJUST_MODE <= 1'b1;                                 // (R10) (R11)
            PW_CLEAR <= CFG_PW_EMPTY & CFG_MASTER_OK;               // (R16)
            // Sum full-scale is the reference for sums and diffs
            ANALOG_OUTPUT_ONE_FS <= CFG_ANALOG_OUTPUT_ONE_SEL[2] ? CFG_FS_SUM :
                        (CFG_ANALOG_OUTPUT_ONE_SEL[0] ? CFG_FS_B : CFG_FS_A);   // (R12) (R13) (R14)
            ANALOG_OUTPUT_TWO_FS <= CFG_ANALOG_OUTPUT_TWO_SEL[2] ? CFG_FS_SUM :
                        (CFG_ANALOG_OUTPUT_TWO_SEL[0] ? CFG_FS_B : CFG_FS_A);   // (R13) (R14)
         end
      end
   end

   // ****************************************
   // Millisecond tick and interval timers
   // ****************************************
   reg [17:0] ms_div;
   reg        ms_tick;
   reg [15:0] can_cnt;
   reg        can_due;
   reg [17:0] ser_cnt;
   reg        ser_due;
   wire [17:0] ser_lim = {10'h000, ser_ivl} * `LVTF_MS_PER_S;

   // One-cycle enable per millisecond
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ms_div  <= 18'h00000;
         ms_tick <= 1'b0;
         can_cnt <= 16'h0000;
         ser_cnt <= 18'h00000;
         can_due <= 1'b0;
         ser_due <= 1'b0;
      end else begin
         ms_tick <= (ms_div == CYC_PER_MS - 1);
         ms_div  <= (ms_div == CYC_PER_MS - 1) ? 18'h00000 : ms_div + 18'h00001;
         can_due <= 1'b0;
         ser_due <= 1'b0;
         if (ms_tick) begin
            if (can_cnt + 16'h0001 >= can_ivl) begin                // (R1)
               can_cnt <= 16'h0000;
               can_due <= can_on;
            end else
               can_cnt <= can_cnt + 16'h0001;
            if (ser_cnt + 18'h00001 >= ser_lim) begin               // (R9)
               ser_cnt <= 18'h00000;
               ser_due <= (ser_mode != `LVTF_MODE_OFF);
            end else
               ser_cnt <= ser_cnt + 18'h00001;
         end
      end
   end

   // Byte order of a float on the wire
   function [31:0] ord;
      input [31:0] f;
      begin
         ord = BIG_ENDIAN ? f : {f[7:0], f[15:8], f[23:16], f[31:24]};  // (R17)
      end
   endfunction

   // ****************************************
   // CAN frame sender
   // ****************************************
   reg can_second;

   // Frame pair per period; the second waits for the first to be taken
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         CAN_VALID  <= 1'b0;
         CAN_ID     <= 11'h000;
         CAN_DLC    <= 4'h0;
         CAN_DATA   <= 64'h0;
         can_second <= 1'b0;
      end else if (CAN_VALID) begin
         if (CAN_READY) begin
            CAN_VALID <= can_second;
            if (can_second) begin
               // From the first frame's id, so a confirm cannot split the pair
               CAN_ID     <= CAN_ID + 11'h001;                       // (R2)
               CAN_DATA   <= {ord(VAL_2A), ord(VAL_2B)};
               can_second <= 1'b0;
            end
         end
      end else if (can_due) begin
         CAN_VALID  <= 1'b1;
         CAN_ID     <= base_id;                                      // (R2)
         CAN_DLC    <= `LVTF_CAN_DLC;
         CAN_DATA   <= {ord(VAL_1A), ord(VAL_1B)};                  // (R17)
         can_second <= 1'b1;
      end
   end

   // ****************************************
   // Serial telegram builder into two-entry buffer
   // ****************************************
   reg [5:0]  pos;
   reg        busy;
   reg [7:0]  frame_checksum_byte;
   reg [7:0]  bbyte;
   reg [7:0]  buf0;
   reg [7:0]  buf1;
   reg [1:0]  cnt;
   reg [5:0]  last;
   reg [127:0] lsr;
   wire       push = busy & (cnt != 2'd2);
   wire       pop  = SER_VALID & SER_READY;

   // Payload byte for the current position of the telegram
   always @* begin
      bbyte = 8'h00;
      case (ser_mode)
         `LVTF_MODE_LSR: begin
            if (pos == 6'd0)
               bbyte = `LVTF_STX;                                    // (R5)
            else if (pos == 6'd1)
               bbyte = `LVTF_LEN;
            else if (pos < 6'd18)
               bbyte = lsr[127 - {pos[3:0] - 4'h2, 3'b000} -: 8];    // (R6)
            else if (pos == 6'd18)
               bbyte = ~frame_checksum_byte;                                        // (R7)
            else
               bbyte = `LVTF_ETX;
         end
         default: begin
            // Formatted text comes from the number formatter by index
            bbyte = (pos == last - 6'd1) ? `LVTF_CR :
                    (pos == last) ? `LVTF_LF : ASCII_CHAR;           // (R3) (R4) (R8)
         end
      endcase
   end

   // Byte walk; a full buffer stalls the walk so no byte is lost
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pos       <= 6'h00;
         busy      <= 1'b0;
         frame_checksum_byte      <= 8'h00;
         lsr       <= 128'h0;
         last      <= 6'h00;
         ASCII_IDX <= 6'h00;
      end else if (!busy) begin
         if (ser_due) begin
            busy <= 1'b1;
            pos  <= 6'h00;
            frame_checksum_byte <= 8'h00;
            ASCII_IDX <= 6'h00;
            lsr  <= {ord(LKZ_A_FIRST), ord(LKZ_A_SECOND),
                     ord(LKZ_B_FIRST), ord(LKZ_B_SECOND)};           // (R6) (R17)
            // Display feed: digits plus CR LF; text line fixed at 62 bytes
            // Display: three plus the digit code, so CR sits at code plus 3
            last <= (ser_mode == `LVTF_MODE_LSR) ? `LVTF_LSR_LAST :
                    (ser_mode == `LVTF_MODE_DISP) ? {4'h0, disp_dig} + 6'd4 :
                    `LVTF_TXT_LAST;                                  // (R8)
         end
      end else if (push) begin
         if (ser_mode == `LVTF_MODE_LSR && pos >= 6'd2 && pos < 6'd18)
            frame_checksum_byte <= frame_checksum_byte + bbyte;                                    // (R7)
         ASCII_IDX <= pos + 6'd1;
         if (pos == last)
            busy <= 1'b0;
         else
            pos <= pos + 6'd1;
      end
   end

   // Two-entry output buffer
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         buf0      <= 8'h00;
         buf1      <= 8'h00;
         cnt       <= 2'd0;
         SER_VALID <= 1'b0;
         SER_DATA  <= 8'h00;
      end else begin
         case ({push, pop})
            2'b10: begin
               if (cnt == 2'd0) buf0 <= bbyte;
               else buf1 <= bbyte;
               cnt <= cnt + 2'd1;
            end
            2'b01: begin
               buf0 <= buf1;
               cnt  <= cnt - 2'd1;
            end
            2'b11: begin
               if (cnt == 2'd1) buf0 <= bbyte;
               else begin
                  buf0 <= buf1;
                  buf1 <= bbyte;
               end
            end
            default: ;
         endcase
         SER_VALID <= (cnt != 2'd0) & ~(pop & cnt == 2'd1 & ~push) | (push & cnt == 2'd0);
         SER_DATA  <= pop ? ((cnt == 2'd2) ? buf1 : bbyte) : ((cnt == 2'd0) ? bbyte : buf0);
      end
   end

endmodule // lvtf_framer
`default_nettype wire

// *** bench/lvtf_framer_properties.sv ***
// Port-level checks for the telemetry framer
`default_nettype none
module lvtf_framer_props (
   input wire logic        CLK,
   input wire logic        RESET_N,
   input wire logic        CFG_OK,
   input wire logic        CFG_SINGLE_SIG,
   input wire logic        CFG_PW_EMPTY,
   input wire logic        CFG_MASTER_OK,
   input wire logic        CAN_VALID,
   input wire logic        CAN_READY,
   input wire logic [10:0] CAN_ID,
   input wire logic [3:0]  CAN_DLC,
   input wire logic [63:0] CAN_DATA,
   input wire logic        SER_VALID,
   input wire logic        SER_READY,
   input wire logic [7:0]  SER_DATA,
   input wire logic        ADJUST_MODE,
   input wire logic        PW_CLEAR,
   input wire logic [15:0] ANALOG_OUTPUT_ONE_FS
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       second;
   logic       ok_q;
   logic [2:0] since_ok;
   // Pair half and age of the last confirm; reset counts as a confirm
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         second   <= 1'b0;
         ok_q     <= 1'b0;
         since_ok <= 3'h0;
      end else begin
         ok_q <= CFG_OK;
         if (CAN_VALID && CAN_READY) second <= ~second;
         if (CFG_OK && !ok_q) since_ok <= 3'h0;
         else if (since_ok != 3'h7) since_ok <= since_ok + 3'h1;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   sequence s_accept; CAN_VALID && CAN_READY; endsequence
   sequence s_confirm; $rose(CFG_OK); endsequence
   can_dlc_fixed_a: assert property (CAN_VALID |-> CAN_DLC == 4'h8)
      else $error("frame length not eight");
   can_hold_a: assert property (CAN_VALID && !CAN_READY |=>
      CAN_VALID && $stable(CAN_ID) && $stable(CAN_DATA)) else $error("frame dropped in stall");
   can_pair_order_a: assert property (s_accept ##0 !second |=>
      CAN_VALID && CAN_ID == $past(CAN_ID) + 11'h1) else $error("second frame id wrong");
   ser_hold_a: assert property (SER_VALID && !SER_READY |=>
      SER_VALID && $stable(SER_DATA)) else $error("serial byte lost in stall");
   adjust_sticky_a: assert property (ADJUST_MODE |=> ADJUST_MODE)
      else $error("adjust mode left early");
   adjust_on_single_a: assert property (s_confirm ##0 CFG_SINGLE_SIG |->
      ##[1:3] ADJUST_MODE) else $error("single signal without adjust");
   pw_clear_a: assert property (s_confirm ##0 (CFG_PW_EMPTY && CFG_MASTER_OK) |->
      ##[1:3] PW_CLEAR ##1 !PW_CLEAR) else $error("password clear missing");
   aout_on_ok_a: assert property ($changed(ANALOG_OUTPUT_ONE_FS) || PW_CLEAR |-> since_ok < 3'h5)
      else $error("setting applied without confirm");
endmodule // lvtf_framer_props
bind lvtf_framer lvtf_framer_props u_props (.CLK(CLK), .RESET_N(RESET_N), .CFG_OK(CFG_OK),
   .CFG_SINGLE_SIG(CFG_SINGLE_SIG), .CFG_PW_EMPTY(CFG_PW_EMPTY), .CFG_MASTER_OK(CFG_MASTER_OK),
   .CAN_VALID(CAN_VALID), .CAN_READY(CAN_READY), .CAN_ID(CAN_ID), .CAN_DLC(CAN_DLC),
   .CAN_DATA(CAN_DATA), .SER_VALID(SER_VALID), .SER_READY(SER_READY), .SER_DATA(SER_DATA),
   .ADJUST_MODE(ADJUST_MODE), .PW_CLEAR(PW_CLEAR), .ANALOG_OUTPUT_ONE_FS(ANALOG_OUTPUT_ONE_FS));
`default_nettype wire

// *** bench/lvtf_rx_model.sv ***
// Receiver model for the CAN and serial links
`default_nettype none
module lvtf_rx_model (
   input  wire logic clk,
   input  wire logic rst_n,
   output var  logic can_ready,
   output var  logic ser_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   integer seed;
   integer r;
   initial begin
      seed      = 84;
      can_ready = 1'b0;
      ser_ready = 1'b0;
   end
   // Random stalls, so held words are exercised on both links
   always @(negedge clk) begin
      r = $random(seed);
      can_ready <= rst_n & r[0];
      ser_ready <= rst_n & r[1];
   end
endmodule // lvtf_rx_model
`default_nettype wire

// *** bench/lvtf_framer_tb.sv ***
// Self-checking bench for the telemetry framer
`default_nettype none
module lvtf_framer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MS = 4; // Cycles per millisecond, so link periods fit the run
   logic        clk, rst_n, cfg_ok, can_on, single, pw_empty, master_ok;
   logic [15:0] can_ivl, fs_a, fs_b, fs_sum, analog_output_one, analog_output_two, e1, e2;
   logic [10:0] base_id, can_id;
   logic [7:0]  ser_ivl, ser_data, sb;
   logic [1:0]  ser_mode, digits, disp_sel;
   logic [2:0]  sel1, sel2;
   logic [31:0] v [8];
   logic [5:0]  ascii_idx;
   logic [3:0]  can_dlc;
   logic [63:0] can_data;
   logic        can_valid, can_ready, ser_valid, ser_ready, adjust, pw_clear;
   wire  [7:0]  ascii_char = 8'h30 + {2'b00, ascii_idx};
   integer      seed, r, k, err_total, cmp_count, pw_cnt;
   lvtf_framer #(.CYC_PER_MS(MS)) u_dut (.CLK(clk), .RESET_N(rst_n), .CFG_OK(cfg_ok),
      .CFG_CAN_ON(can_on),
      .CFG_CAN_IVL_MS(can_ivl), .CFG_CAN_BASE_ID(base_id), .CFG_SER_MODE(ser_mode),
      .CFG_SER_IVL_S(ser_ivl), .CFG_DISP_DIGITS(digits), .CFG_DISP_SEL(disp_sel),
      .CFG_SINGLE_SIG(single), .CFG_FS_A(fs_a), .CFG_FS_B(fs_b), .CFG_FS_SUM(fs_sum),
      .CFG_ANALOG_OUTPUT_ONE_SEL(sel1), .CFG_ANALOG_OUTPUT_TWO_SEL(sel2), .CFG_PW_EMPTY(pw_empty),
      .CFG_MASTER_OK(master_ok), .VAL_1A(v[0]), .VAL_1B(v[1]), .VAL_2A(v[2]), .VAL_2B(v[3]),
      .LKZ_A_FIRST(v[4]), .LKZ_A_SECOND(v[5]), .LKZ_B_FIRST(v[6]), .LKZ_B_SECOND(v[7]),
      .ASCII_CHAR(ascii_char), .ASCII_IDX(ascii_idx), .CAN_VALID(can_valid),
      .CAN_READY(can_ready), .CAN_ID(can_id), .CAN_DLC(can_dlc), .CAN_DATA(can_data),
      .SER_VALID(ser_valid), .SER_READY(ser_ready), .SER_DATA(ser_data), .ADJUST_MODE(adjust),
      .PW_CLEAR(pw_clear), .ANALOG_OUTPUT_ONE_FS(analog_output_one), .ANALOG_OUTPUT_TWO_FS(analog_output_two));
   lvtf_rx_model u_rx (.clk(clk), .rst_n(rst_n), .can_ready(can_ready), .ser_ready(ser_ready));
   // **************************************
   // Helpers
   // **************************************
   function automatic logic [15:0] exp_fs(input logic [2:0] s);
      return s[2] ? fs_sum : (s[0] ? fs_b : fs_a);
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Load frame byte k: start, length, four floats, checksum, end
   function automatic logic [7:0] lsr_byte(input integer k);
      logic [127:0] f;
      logic [7:0]   s;
      f = {v[4], v[5], v[6], v[7]};
      s = 8'h00;
      for (integer i = 0; i < 16; i++) s = s + f[127 - 8 * i -: 8];
      if (k == 0) return 8'h02;
      else if (k == 1) return 8'h16;
      else if (k < 18) return f[127 - 8 * (k - 2) -: 8];
      else if (k == 18) return ~s;
      else return 8'h03;
   endfunction
   // Text byte k of a line ending at index n: formatter text, then CR LF
   function automatic logic [7:0] txt_byte(input integer k, input integer n);
      return (k == n - 1) ? 8'h0d : (k == n) ? 8'h0a : 8'h30 + k[7:0];
   endfunction
   // Edges at which the receiver takes a frame or a byte
   task automatic take_can;
      @(posedge clk);
      while (!(can_valid === 1'b1 && can_ready === 1'b1)) @(posedge clk);
   endtask
   task automatic take_ser(output logic [7:0] b);
      @(posedge clk);
      while (!(ser_valid === 1'b1 && ser_ready === 1'b1)) @(posedge clk);
      b = ser_data;
   endtask
   // Edges from the current one to the next rise of the frame valid
   task automatic to_can_rise(output integer c);
      c = 0;
      do begin
         c++;
         @(posedge clk);
      end while (can_valid !== 1'b0);
      do begin
         c++;
         @(posedge clk);
      end while (can_valid !== 1'b1);
   endtask
   task automatic close_out;
      $display("compares %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One-cycle confirm, then time for the settings to land
   task automatic confirm;
      @(negedge clk) cfg_ok = 1'b1;
      @(negedge clk) cfg_ok = 1'b0;
      repeat (4) @(negedge clk);
   endtask
   // Legal random settings; intervals kept inside their clamps
   task automatic shuffle;
      r = $random(seed);
      can_ivl = 16'd50 + r[15:0] % 16'd4951;
      ser_ivl = 8'd1 + r[23:16] % 8'd240;
      digits = 2'd1 + r[25:24] % 2'd3;
      disp_sel = r[27:26];
      pw_empty = r[28];
      r = $random(seed);
      {fs_a, base_id, sel1, sel2} = {r[15:0], r[26:16], r[29:27], r[31:30], r[0]};
      r = $random(seed);
      {fs_b, fs_sum} = r;
      for (k = 0; k < 8; k++) v[k] = $random(seed);
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) if (pw_clear === 1'b1) pw_cnt++;
   // Three serial periods of about 4000 cycles each fit well inside this ceiling
   initial begin
      #150000;
      err_total++;
      close_out;
   end
   // **************************************
   // Scenarios
   // **************************************
   initial begin
      {seed, err_total, cmp_count, pw_cnt} = {32'd84, 96'h0};
      {rst_n, cfg_ok, can_on, single, master_ok, ser_mode} = 7'h0;
      shuffle;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk({15'h0, adjust}, 16'h0);
      can_on = 1'b1;
      for (integer n = 0; n < 12; n++) begin
         shuffle;
         if (n == 0) {fs_a, fs_b, fs_sum, sel1, sel2} = {16'hffff, 16'h0, 16'h0001, 6'h0c};
         ser_mode = n[1:0];
         confirm;
         {e1, e2} = {exp_fs(sel1), exp_fs(sel2)};
         chk(analog_output_one, e1);
         chk(analog_output_two, e2);
         shuffle;
         repeat (3) @(negedge clk);
         chk(analog_output_one, e1);
      end
      chk(pw_cnt[15:0], 16'h0);
      {pw_empty, master_ok} = 2'b11;
      confirm;
      chk(pw_cnt[15:0], 16'h1);
      {pw_empty, single} = 2'b01;
      confirm;
      chk({15'h0, adjust}, 16'h1);
      chk(pw_cnt[15:0], 16'h1);
      single = 1'b0;
      confirm;
      chk({15'h0, adjust}, 16'h1);
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk({15'h0, adjust}, 16'h0);
      // Links after a fresh reset: shortest CAN period, then each serial mode
      {can_ivl, ser_ivl, ser_mode, can_on} = {16'd50, 8'd1, 2'd2, 1'b1};
      confirm;
      take_can;
      chk({5'h0, can_id}, {5'h0, base_id});
      chk({12'h0, can_dlc}, 16'h0008);
      chk64(can_data, {v[0], v[1]});
      take_can;
      chk({5'h0, can_id}, {5'h0, base_id + 11'h001});
      chk64(can_data, {v[2], v[3]});
      to_can_rise(k);
      to_can_rise(k);
      chk(k[15:0], can_ivl * MS[15:0]);
      for (k = 0; k < 20; k++) begin
         take_ser(sb);
         chk({8'h0, sb}, {8'h0, lsr_byte(k)});
      end
      @(negedge clk) ser_mode = 2'd1;
      confirm;
      for (k = 0; k < 62; k++) begin
         take_ser(sb);
         chk({8'h0, sb}, {8'h0, txt_byte(k, 61)});
      end
      @(negedge clk) {ser_mode, digits} = {2'd3, 2'd2};
      confirm;
      for (k = 0; k < 7; k++) begin
         take_ser(sb);
         chk({8'h0, sb}, {8'h0, txt_byte(k, 6)});
      end
      close_out;
   end
endmodule // lvtf_framer_tb
`default_nettype wire
